// file: core/pidd_pkg.sv
// shared constants and types for the port direction and drive block
package pidd_pkg;

    // pin count of the port
    localparam int PIN_W = 8;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_OUT_VALUE = 10'h250;
    localparam logic [9:0] IDX_SNAPSHOT = 10'h251;
    localparam logic [9:0] IDX_DIRECTION = 10'h252;
    localparam logic [9:0] IDX_DRIVE_SEL = 10'h253;

    // reset values
    localparam logic [7:0] RST_OUT_VALUE = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_DRIVE_SEL = 8'h00;

    // pin groups taken over by peripherals
    localparam logic [7:0] SSU_PIN_MASK = 8'h3C;
    localparam int SSU_LSB = 2;
    localparam int SERIAL_TX_PIN = 1;
    localparam int SERIAL_RX_PIN = 0;

    // bus answer phase
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_ANSWER
    } pidd_bus_e;

    // all registered state of the top module
    typedef struct packed {
        logic [7:0] out_value;
        logic [7:0] direction;
        logic [7:0] drive_sel;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] pin_val;
        logic [7:0] pin_oe;
        logic [7:0] pin_red;
        logic [31:0] rdata;
        logic wreq;
        pidd_bus_e phase;
    } pidd_state_s;

endpackage

// file: core/pidd_pin_if.sv
// per-pin control bundle between register file and pin resolver
`timescale 1ns/1ps
`default_nettype none
interface pidd_pin_if;
    logic [7:0] direction;
    logic [7:0] out_value;
    logic [7:0] drive_sel;
    logic ssu_en;
    logic [3:0] ssu_oe;
    logic [3:0] ssu_out;
    logic fbc_en;
    logic fbc_tx;
    logic asu_en;
    logic asu_tx;
    logic [7:0] eff_oe;
    logic [7:0] eff_val;
    logic [7:0] eff_red;

    modport ctrl (
        output direction, out_value, drive_sel, ssu_en, ssu_oe, ssu_out,
        output fbc_en, fbc_tx, asu_en, asu_tx,
        input eff_oe, eff_val, eff_red
    );
    modport res (
        input direction, out_value, drive_sel, ssu_en, ssu_oe, ssu_out,
        input fbc_en, fbc_tx, asu_en, asu_tx,
        output eff_oe, eff_val, eff_red
    );
endinterface
`default_nettype wire

// file: core/pidd_pin_resolve.sv
// resolves per-pin direction, value and drive from registers and peripherals
`timescale 1ns/1ps
`default_nettype none
module pidd_pin_resolve (
    pidd_pin_if.res p // control bundle
);
    logic serial_en;
    logic serial_tx;
    logic [7:0] force_en;
    logic [7:0] force_oe;
    logic [7:0] force_val;

    // forced choice when a peripheral owns the pin
    function automatic logic pick(input logic sel, input logic frc, input logic sw);
        pick = sel ? frc : sw;
    endfunction

    // fieldbus wins the tx pin if both serial units are enabled
    always_comb begin
        serial_en = p.fbc_en | p.asu_en;
        serial_tx = p.fbc_en ? p.fbc_tx : p.asu_tx;
        force_en = ({8{p.ssu_en}} & pidd_pkg::SSU_PIN_MASK)
            | {6'h00, serial_en, serial_en}; // RULE5 RULE7 RULE8
        force_oe = {2'b00, p.ssu_oe, 2'b10}; // RULE7 RULE8
        force_val = {2'b00, p.ssu_out, serial_tx, 1'b0};
    end

    // direction bit is only read here, never written, so overrides leave it intact
    for (genvar i = 0; i < pidd_pkg::PIN_W; i++) begin : g_pin
        always_comb begin
            p.eff_oe[i] = pick(force_en[i], force_oe[i], p.direction[i]); // RULE4 RULE6
            p.eff_val[i] = pick(force_en[i], force_val[i], p.out_value[i]); // RULE12
            // reduction follows any output, whoever drives it
            p.eff_red[i] = p.drive_sel[i] & p.eff_oe[i]; // RULE9 RULE10 RULE11
        end
    end
endmodule
`default_nettype wire

// file: core/pidd_port.sv
// eight-pin port: input snapshot, direction, drive select, avalon-mm slave
//
// Functional notes
// RULE1 - snapshot read returns buffered state of all pins
// RULE2 - snapshot register ignores every write
// RULE3 - snapshot also shows pins driven as outputs
// RULE4 - direction bit one output, zero input
// RULE5 - enabled synchronous serial forces pins five to two
// RULE6 - peripheral override never changes stored direction bit
// RULE7 - fieldbus or async serial forces pin one out
// RULE8 - fieldbus or async serial forces pin zero in
// RULE9 - drive select one reduced, zero full
// RULE10 - drive select ignored on input pins
// RULE11 - reduced drive applies to peripheral outputs too
// RULE12 - unowned output pin drives the data register bit
// RULE13 - writes land on completing edge, pins sampled
`timescale 1ns/1ps
`default_nettype none
module pidd_port (
    input wire logic mclk_i, // 100 MHz system clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic [11:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall, low for one answer cycle
    input wire logic ssu_en_i, // synchronous serial unit enabled
    input wire logic [3:0] ssu_oe_i, // its direction for pins 5..2
    input wire logic [3:0] ssu_out_i, // its output value for pins 5..2
    input wire logic fbc_en_i, // fieldbus controller enabled
    input wire logic fbc_tx_i, // fieldbus transmit bit
    input wire logic asu_en_i, // async serial unit enabled
    input wire logic asu_tx_i, // async serial transmit bit
    input wire logic [7:0] pin_i, // pad input levels, asynchronous
    output logic [7:0] pin_o, // pad output value
    output logic [7:0] pin_oe_o, // pad output enable, high drives
    output logic [7:0] pin_reduced_o // pad reduced drive select
);
    pidd_pkg::pidd_state_s q;
    pidd_pkg::pidd_state_s d;
    logic [9:0] idx;
    logic req;
    logic accept;
    logic wr_lane;

    pidd_pin_if pins ();

    // registers feed the resolver straight from the flops
    assign pins.direction = q.direction;
    assign pins.out_value = q.out_value;
    assign pins.drive_sel = q.drive_sel;
    assign pins.ssu_en = ssu_en_i;
    assign pins.ssu_oe = ssu_oe_i;
    assign pins.ssu_out = ssu_out_i;
    assign pins.fbc_en = fbc_en_i;
    assign pins.fbc_tx = fbc_tx_i;
    assign pins.asu_en = asu_en_i;
    assign pins.asu_tx = asu_tx_i;

    pidd_pin_resolve u_resolve (
        .p (pins.res)
    );

    // decode used by both read and write paths
    function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
        hit = (a == r);
    endfunction

    // bus request decode
    always_comb begin
        idx = avs_address_i[11:2];
        req = avs_read_i | avs_write_i;
        accept = req & ~q.wreq; // RULE13
        wr_lane = avs_write_i & accept & avs_byteenable_i[0];
    end

    // next state
    always_comb begin
        d = q;
        // two-stage synchroniser; first stage only feeds the second
        d.sync1 = pin_i; // RULE13
        d.sync2 = q.sync1; // RULE1 RULE3
        // pin outputs registered so pads see clean flop edges
        d.pin_oe = pins.eff_oe;
        d.pin_val = pins.eff_val;
        d.pin_red = pins.eff_red;
        // one-cycle answer after a cycle of wait
        case (q.phase)
            pidd_pkg::BUS_IDLE: begin
                d.wreq = 1'b1;
                if (req) begin
                    d.phase = pidd_pkg::BUS_ANSWER;
                    d.wreq = 1'b0;
                end
            end
            pidd_pkg::BUS_ANSWER: begin
                d.phase = pidd_pkg::BUS_IDLE;
                d.wreq = 1'b1;
            end
            default: begin
                d.phase = pidd_pkg::BUS_IDLE;
                d.wreq = 1'b1;
            end
        endcase
        // read data latched in the wait cycle, stands at the answer edge
        d.rdata = 32'h0000_0000;
        if (avs_read_i && q.phase == pidd_pkg::BUS_IDLE) begin
            if (hit(idx, pidd_pkg::IDX_SNAPSHOT)) begin
                d.rdata[7:0] = q.sync2; // RULE1 RULE3
            end else if (hit(idx, pidd_pkg::IDX_DIRECTION)) begin
                d.rdata[7:0] = q.direction;
            end else if (hit(idx, pidd_pkg::IDX_DRIVE_SEL)) begin
                d.rdata[7:0] = q.drive_sel;
            end else if (hit(idx, pidd_pkg::IDX_OUT_VALUE)) begin
                // output pins read the latch, input pins the buffered pad
                d.rdata[7:0] = (q.out_value & q.direction) | (q.sync2 & ~q.direction);
            end
        end
        // writes land on the edge that completes the access
        if (wr_lane) begin
            if (hit(idx, pidd_pkg::IDX_DIRECTION)) begin
                d.direction = avs_writedata_i[7:0]; // RULE4 RULE13
            end
            if (hit(idx, pidd_pkg::IDX_DRIVE_SEL)) begin
                d.drive_sel = avs_writedata_i[7:0]; // RULE9
            end
            if (hit(idx, pidd_pkg::IDX_OUT_VALUE)) begin
                d.out_value = avs_writedata_i[7:0]; // RULE12
            end
            // snapshot and unmapped indices fall through untouched
        end
    end

    // single state register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            q.out_value <= pidd_pkg::RST_OUT_VALUE;
            q.direction <= pidd_pkg::RST_DIRECTION;
            q.drive_sel <= pidd_pkg::RST_DRIVE_SEL;
            q.sync1 <= 8'h00;
            q.sync2 <= 8'h00;
            q.pin_val <= 8'h00;
            q.pin_oe <= 8'h00;
            q.pin_red <= 8'h00;
            q.rdata <= 32'h0000_0000;
            q.wreq <= 1'b1;
            q.phase <= pidd_pkg::BUS_IDLE;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.wreq;
    assign pin_o = q.pin_val;
    assign pin_oe_o = q.pin_oe;
    assign pin_reduced_o = q.pin_red;

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_done;
        req && !avs_waitrequest_o;
    endsequence

    sequence s_snap_read;
        s_done ##0 avs_read_i && hit(idx, pidd_pkg::IDX_SNAPSHOT);
    endsequence

    sequence s_snap_write;
        s_done ##0 avs_write_i && hit(idx, pidd_pkg::IDX_SNAPSHOT);
    endsequence

    sequence s_dir_write;
        s_done ##0 avs_write_i && avs_byteenable_i[0]
            ##0 hit(idx, pidd_pkg::IDX_DIRECTION);
    endsequence

    AST_SNAP_READ: assert property (s_snap_read |-> avs_readdata_o[7:0] == $past(q.sync2)) // RULE1
        else $error("snapshot read does not match buffered pins");
    AST_SNAP_RO: assert property (s_snap_write |=> $stable(q.direction)
            && $stable(q.drive_sel) && $stable(q.out_value)) // RULE2
        else $error("write to snapshot changed port state");
    AST_PIN_SYNC: assert property (##2 1'b1 |-> q.sync2 == $past(pin_i, 2)) // RULE3
        else $error("buffered pin state not two cycles behind pad");
    AST_DIR_PLAIN: assert property (!ssu_en_i && !fbc_en_i && !asu_en_i
            |=> pin_oe_o == $past(q.direction)) // RULE4
        else $error("unforced pin direction differs from register");
    AST_SSU_FORCE: assert property (ssu_en_i |=> pin_oe_o[5:2] == $past(ssu_oe_i)
            && pin_o[5:2] == $past(ssu_out_i)) // RULE5
        else $error("synchronous serial override not applied");
    AST_DIR_KEEP: assert property (!(avs_write_i && accept) |=> $stable(q.direction)) // RULE6
        else $error("direction register changed without a write");
    AST_TX_OUT: assert property (fbc_en_i || asu_en_i |=> pin_oe_o[1]) // RULE7
        else $error("serial transmit pin not forced to output");
    AST_RX_IN: assert property (fbc_en_i || asu_en_i |=> !pin_oe_o[0]) // RULE8
        else $error("serial receive pin not forced to input");
    AST_REDUCE: assert property (##1 1'b1 |-> pin_reduced_o == ($past(q.drive_sel) & pin_oe_o)) // RULE9
        else $error("reduced drive does not follow select and direction");
    AST_REDUCE_IN: assert property (!pin_oe_o[7] |-> !pin_reduced_o[7]) // RULE10
        else $error("reduced drive asserted on input pin");
    AST_REDUCE_PERIPH: assert property (fbc_en_i ##1 fbc_en_i |-> pin_reduced_o[1]
            == $past(q.drive_sel[1])) // RULE11
        else $error("reduced drive ignored on peripheral output");
    AST_GPIO_DRIVE: assert property (!ssu_en_i && !fbc_en_i && !asu_en_i
            |=> pin_o == $past(q.out_value)) // RULE12
        else $error("output pin not driven from data register");
    AST_WRITE_EDGE: assert property (s_dir_write |=> q.direction == $past(avs_writedata_i[7:0])) // RULE13
        else $error("direction write not taken at completing edge");
    AST_ONE_WAIT: assert property (req && avs_waitrequest_o && q.phase == pidd_pkg::BUS_IDLE
            |=> !avs_waitrequest_o) // RULE13
        else $error("slave did not answer in one cycle");

endmodule
`default_nettype wire

// file: testbench/pidd_tb.sv
// self-checking bench for the port direction and drive block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [11:0] address = 12'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic ssu_en = 1'b0, fbc_en = 1'b0, asu_en = 1'b0, fbc_tx = 1'b0, asu_tx = 1'b0;
    logic [3:0] ssu_oe = 4'h0, ssu_out = 4'h0;
    logic [7:0] pin_in = 8'h00, pin_out, pin_oe, pin_red, d, r, o, eoe;
    logic [31:0] seed = 32'hF6D7795B;
    logic [31:0] expq[$];
    int failures = 0;
    int compares = 0;

    pidd_port dut (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(address),
        .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(writedata),
        .avs_byteenable_i(byteenable), .avs_readdata_o(readdata),
        .avs_waitrequest_o(waitrequest), .ssu_en_i(ssu_en), .ssu_oe_i(ssu_oe),
        .ssu_out_i(ssu_out), .fbc_en_i(fbc_en), .fbc_tx_i(fbc_tx), .asu_en_i(asu_en),
        .asu_tx_i(asu_tx), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe),
        .pin_reduced_o(pin_red));

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic rnd(output logic [7:0] v);
        seed = lfsr(seed);
        v = seed[7:0];
    endtask

    // one avalon access; waitrequest sampled at the rising edge, released only after it
    task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] dat,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge mclk_i);
        address <= {idx, 2'b00};
        writedata <= {24'h0, dat};
        byteenable <= be;
        read <= ~w;
        write <= w;
        // no wait limit here: only the watchdog ends a hung access
        do begin
            @(posedge mclk_i);
            n++;
        end while (waitrequest !== 1'b0);
        chk("wait cycles", n, 32'h2);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        expq.push_back({24'h0, exp});
        bus(1'b0, idx, 8'h00, 4'hF);
    endtask

    // flops behind registers and pins need a few edges to land
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    // watches the answer cycle and takes the oldest expected read value
    always @(negedge mclk_i) begin
        if (read && waitrequest === 1'b0) begin
            if (expq.size() == 0) chk("unexpected read", 32'h1, 32'h0);
            else chk("readdata", readdata, expq.pop_front());
        end
    end

    // watchdog, far beyond the fewer than two hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        conclude();
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(pidd_pkg::IDX_DIRECTION, pidd_pkg::RST_DIRECTION);
        rd(pidd_pkg::IDX_DRIVE_SEL, pidd_pkg::RST_DRIVE_SEL);
        rd(10'h000, 8'h00);
        chk("pin_oe reset", {24'h0, pin_oe}, 32'h0);
        $display("test reset done");
        // gpio mode with random registers and pads
        for (int i = 0; i < 4; i++) begin
            rnd(d);
            rnd(r);
            rnd(o);
            bus(1'b1, pidd_pkg::IDX_DIRECTION, d, 4'hF);
            bus(1'b1, pidd_pkg::IDX_DRIVE_SEL, r, 4'hF);
            bus(1'b1, pidd_pkg::IDX_OUT_VALUE, o, 4'hF);
            bus(1'b1, pidd_pkg::IDX_SNAPSHOT, ~d, 4'hF);
            bus(1'b1, pidd_pkg::IDX_DIRECTION, ~d, 4'hE);
            @(posedge mclk_i);
            pin_in <= seed[15:8];
            settle();
            rd(pidd_pkg::IDX_DIRECTION, d);
            rd(pidd_pkg::IDX_DRIVE_SEL, r);
            rd(pidd_pkg::IDX_SNAPSHOT, pin_in);
            chk("pin_oe", {24'h0, pin_oe}, {24'h0, d});
            chk("pin_o", {24'h0, pin_out & d}, {24'h0, o & d});
            chk("pin_red", {24'h0, pin_red}, {24'h0, r & d});
        end
        $display("test gpio done");
        // synchronous serial unit takes pins 5..2
        @(posedge mclk_i);
        ssu_en <= 1'b1;
        ssu_oe <= seed[19:16];
        ssu_out <= seed[23:20];
        settle();
        eoe = (d & ~pidd_pkg::SSU_PIN_MASK) | {2'b00, ssu_oe, 2'b00};
        chk("pin_oe ssu", {24'h0, pin_oe}, {24'h0, eoe});
        chk("pin_o ssu", {28'h0, pin_out[5:2] & ssu_oe}, {28'h0, ssu_out & ssu_oe});
        chk("pin_red ssu", {24'h0, pin_red}, {24'h0, r & eoe});
        rd(pidd_pkg::IDX_DIRECTION, d);
        @(posedge mclk_i);
        ssu_en <= 1'b0;
        $display("test ssu done");
        // fieldbus, async serial and both: pin 1 out, pin 0 in
        bus(1'b1, pidd_pkg::IDX_DIRECTION, 8'h01, 4'hF);
        bus(1'b1, pidd_pkg::IDX_DRIVE_SEL, 8'hFF, 4'hF);
        for (int m = 1; m < 4; m++) begin
            seed = lfsr(seed);
            @(posedge mclk_i);
            fbc_en <= m[0];
            asu_en <= m[1];
            fbc_tx <= seed[0];
            asu_tx <= seed[1];
            settle();
            chk("pin_oe serial", {30'h0, pin_oe[1:0]}, 32'h2);
            chk("pin_o tx", {31'h0, pin_out[1]}, {31'h0, m[0] ? seed[0] : seed[1]});
            chk("pin_red serial", {30'h0, pin_red[1:0]}, 32'h2);
            rd(pidd_pkg::IDX_DIRECTION, 8'h01);
        end
        $display("test serial done");
        repeat (3) @(posedge mclk_i);
        chk("pending reads", expq.size(), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
